/* File: hw/plsr_pkg.sv */
/*
 package of constants for the parallel-load shift register block.
 assumes one 200 MHz clock and a classic Wishbone slave with 32-bit data.
*/
// Behaviour
// (R1) shift mode: serial in, stages move one place
// (R2) load mode: parallel byte taken on edge
// (R3) load ignores the serial input entirely
// (R4) stages move on rising NOR of clock, inhibit
// (R5) either gated input high freezes all stages
// (R6) either gated input may act as clock
// (R7) free clock may run while register halted
// (R8) host raises inhibit only while clock high
// (R9) clear zeroes all stages, overrides everything
// (R10) data leaves only serially from last stage; the core also shows all stages in the status register
// (R11) no edge, no clear: stages hold value
package plsr_pkg;
   // =======================================================
   // geometry
   localparam int PLSR_STAGES = 8;
   localparam int PLSR_BUF_DEPTH = 2;
   // =======================================================
   // register map, byte addresses
   localparam logic [3:0] PLSR_CTRL_OFS = 4'h0;
   localparam logic [3:0] PLSR_STATUS_OFS = 4'h4;
   // control fields
   localparam int PLSR_CTRL_CLEAR_BIT = 0;
   localparam int PLSR_CTRL_HALT_BIT = 1;
   localparam logic PLSR_HALT_RESET = 1'h0;
   // status fields
   localparam int PLSR_STAT_STAGES_LSB = 0;
   localparam int PLSR_STAT_ROOM_BIT = 8;
   localparam int PLSR_STAT_HALT_BIT = 9;
   // =======================================================
   // reset values
   localparam logic [7:0] PLSR_STAGES_RESET = 8'h00;
   localparam logic PLSR_COMB_CLK_RESET = 1'h1;
   localparam logic [31:0] PLSR_READ_ZERO = 32'h0000_0000;
endpackage

/* File: hw/plsr_buffer.sv */
/*
 two-entry buffer with valid and ready on both sides.
 assumes a single clock and synchronous active-low reset.
*/
`timescale 1ns/1ps
module plsr_buffer
   import plsr_pkg::*;
#(
   parameter int WIDTH = 1,
   parameter int DEPTH = PLSR_BUF_DEPTH
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);
   // =======================================================
   // elaboration checks
   if (DEPTH != 2) begin : g_bad_depth
      $error("plsr_buffer serves exactly two entries");
   end
   if (WIDTH < 1) begin : g_bad_width
      $error("plsr_buffer width must be positive");
   end

   // =======================================================
   // entry 0 is the head, entry 1 the spare
   logic [WIDTH-1:0] spare_data;
   logic spare_valid;
   wire push = in_valid & in_ready;
   wire pop = out_valid & out_ready;
   wire [1:0] count = {1'b0, out_valid} + {1'b0, spare_valid};
   wire [1:0] next_count = count + {1'b0, push} - {1'b0, pop};

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         out_valid <= 1'b0;
         spare_valid <= 1'b0;
         in_ready <= 1'b1;
         out_data <= '0;
         spare_data <= '0;
      end else begin
         out_valid <= (next_count != 2'h0);
         spare_valid <= (next_count == 2'h2);
         in_ready <= (next_count != 2'h2);
         if (pop) begin
            out_data <= spare_valid ? spare_data : in_data;
         end else if (push && !out_valid) begin
            out_data <= in_data;
         end
         if (push && (out_valid && !pop || spare_valid)) begin
            spare_data <= in_data;
         end
      end
   end
endmodule

/* File: hw/plsr_core.sv */
/*
 eight-stage parallel-load shift register with gated clock and overriding clear.
 pins are sampled inputs synchronous to clock; a Wishbone slave gives a soft
 clear, a halt and a view of the stages; serial bits leave through a buffer.
*/
`timescale 1ns/1ps
module plsr_core
   import plsr_pkg::*;
#(
   parameter int STAGES = PLSR_STAGES
) (
   input wire logic clock,
   input wire logic rst_n,
   // device pins
   input wire logic shift_not_load,
   input wire logic serial_in,
   input wire logic [STAGES-1:0] parallel_in,
   input wire logic device_clock,
   input wire logic clock_inhibit,
   input wire logic overriding_reset_n,
   output logic last_stage_out,
   // serial stream of each last-stage bit set by an active edge, not by clear, that finds room in the buffer
   output logic stream_valid,
   output logic stream_bit,
   input wire logic stream_ready,
   output logic stream_room,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o
);
   // =======================================================
   // elaboration checks
   if (STAGES != 8) begin : g_bad_stages
      $error("plsr_core status layout serves eight stages");
   end

   // =======================================================
   // register state
   logic [STAGES-1:0] stages;
   logic [STAGES-1:0] next_stages;
   logic comb_clk_prev;
   logic halt;
   logic soft_clear;

   // =======================================================
   // gated clock and clear
   wire comb_clk = ~(device_clock | clock_inhibit); // see (R4) (R5) (R6)
   wire comb_edge = comb_clk & ~comb_clk_prev; // see (R4)
   wire active_edge = comb_edge & ~halt; // see (R7)
   wire clear = ~overriding_reset_n | soft_clear; // see (R9)

   // =======================================================
   // stage update
   genvar gi;
   generate
      for (gi = 0; gi < STAGES; gi++) begin : g_stage
         if (gi == 0) begin : g_first
            // load ignores serial_in, see (R3)
            assign next_stages[gi] = shift_not_load ? serial_in : parallel_in[gi]; // see (R1) (R2)
         end else begin : g_rest
            assign next_stages[gi] = shift_not_load ? stages[gi-1] : parallel_in[gi]; // see (R1) (R2)
         end
      end
   endgenerate

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         stages <= PLSR_STAGES_RESET;
         comb_clk_prev <= PLSR_COMB_CLK_RESET;
      end else begin
         comb_clk_prev <= comb_clk;
         if (clear) begin
            stages <= PLSR_STAGES_RESET; // see (R9)
         end else if (active_edge) begin
            stages <= next_stages;
         end
         // otherwise all stages hold, see (R11) (R5)
      end
   end

   assign last_stage_out = stages[STAGES-1]; // see (R10)

   // =======================================================
   // serial stream through the two-entry buffer
   wire push_bit = active_edge & ~clear; // see (R10)
   logic buf_in_ready;

   plsr_buffer #(
      .WIDTH(1),
      .DEPTH(PLSR_BUF_DEPTH)
   ) u_buffer (
      .clock(clock),
      .rst_n(rst_n),
      .in_valid(push_bit),
      .in_data(next_stages[STAGES-1]),
      .in_ready(buf_in_ready),
      .out_valid(stream_valid),
      .out_data(stream_bit),
      .out_ready(stream_ready)
   );
   assign stream_room = buf_in_ready;

   // =======================================================
   // wishbone slave
   wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire hit_ctrl = (wb_adr_i == PLSR_CTRL_OFS);
   wire hit_status = (wb_adr_i == PLSR_STATUS_OFS);
   wire ctrl_wr = wb_req & wb_we_i & hit_ctrl & wb_sel_i[0];
   wire [31:0] ctrl_view = {30'h0000_0000, halt, 1'b0};
   wire [31:0] status_view = {22'h00_0000, halt, buf_in_ready, stages};
   wire [31:0] read_mux = hit_ctrl ? ctrl_view : (hit_status ? status_view : PLSR_READ_ZERO);

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= PLSR_READ_ZERO;
         halt <= PLSR_HALT_RESET;
         soft_clear <= 1'b0;
      end else begin
         wb_ack_o <= wb_req;
         wb_dat_o <= (wb_req && !wb_we_i) ? read_mux : PLSR_READ_ZERO;
         soft_clear <= ctrl_wr & wb_dat_i[PLSR_CTRL_CLEAR_BIT];
         if (ctrl_wr) begin
            halt <= wb_dat_i[PLSR_CTRL_HALT_BIT]; // see (R7)
         end
      end
   end
endmodule

/* File: testbench/plsr_monitor.sv */
/*
 checker on the plsr_core ports.
 assumes pins are sampled on clock and halt is set over the bus.
*/
`timescale 1ns/1ps
module plsr_monitor #(
   parameter int STAGES = 8
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic shift_not_load,
   input wire logic [STAGES-1:0] parallel_in,
   input wire logic device_clock,
   input wire logic clock_inhibit,
   input wire logic overriding_reset_n,
   input wire logic last_stage_out,
   input wire logic stream_valid,
   input wire logic stream_bit,
   input wire logic stream_ready,
   input wire logic stream_room,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_o
);
   // ==========
   // halt copy and edge helpers
   logic halt, live, quiet;
   wire comb = ~(device_clock | clock_inhibit);
   wire ok = overriding_reset_n && !halt && live;
   wire ctrl_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == 4'h0 && wb_sel_i[0];
   always_ff @(posedge clock) begin
      live <= rst_n;
      quiet <= !wb_cyc_i;
      halt <= !rst_n ? 1'h0 : (ctrl_wr ? wb_dat_i[1] : halt);
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   sequence edge_s;
      $rose(comb) && ok;
   endsequence
   clear_zeroes_a: assert property (!overriding_reset_n |=> !last_stage_out) else $error("clear missed");
   hold_quiet_a: assert property (overriding_reset_n && !($rose(comb) && ok) && quiet && !wb_cyc_i
      |=> $stable(last_stage_out)) else $error("stage moved");
   load_parallel_a: assert property (edge_s ##0 !shift_not_load
      |=> last_stage_out == $past(parallel_in[STAGES-1])) else $error("load wrong");
   stream_push_a: assert property (edge_s ##0 !stream_valid
      |=> stream_valid && stream_bit == last_stage_out) else $error("push wrong");
   stall_hold_a: assert property (stream_valid && !stream_ready |=> stream_valid && $stable(stream_bit))
      else $error("head lost");
   full_valid_a: assert property (!stream_room |-> stream_valid) else $error("room wrong");
   ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack stuck");
endmodule
bind plsr_core plsr_monitor #(.STAGES(STAGES)) MON (.*);

/* File: testbench/plsr_sink.sv */
/*
 stream consumer model.
 assumes stall comes from the bench.
*/
`timescale 1ns/1ps
module plsr_sink (
   input wire logic clock,
   input wire logic stall,
   input wire logic stream_valid,
   input wire logic stream_bit,
   output logic stream_ready,
   output logic [7:0] got
);
   // ==========
   // one bit taken per valid and ready edge
   assign stream_ready = !stall;
   always_ff @(posedge clock) begin
      if (stream_valid && stream_ready) begin
         got <= {got[6:0], stream_bit};
      end
   end
endmodule

/* File: testbench/plsr_tb.sv */
/*
 bench for plsr_core: pins, stream and bus.
 assumes plsr_monitor and plsr_sink are compiled first.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin bad_count++; \
   $display("wrong value %0t %h %h", $time, a, b); end end
module plsr_tb;
   logic clock = 0, rst_n = 0, shift_not_load = 1, serial_in = 0, device_clock = 1, clock_inhibit = 0;
   logic overriding_reset_n = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, stall = 1;
   logic [7:0] parallel_in = 8'h00, got;
   logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
   logic last_stage_out, stream_valid, stream_bit, stream_ready, stream_room, wb_ack_o;
   int bad_count = 0, total_checks = 0;
   always #2.5 clock = ~clock;
   plsr_core DUT (.*);
   plsr_sink SINK (.*);
   // ==========
   // tasks
   task tally_and_finish;
      if (bad_count == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task wb(input logic we, input logic [3:0] adr, input logic [31:0] dat);
      int n;
      n = 0;
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, we, adr, dat};
      do begin
         @(posedge clock);
         n++;
      end while (wb_ack_o !== 1'h1 && n < 20);
      if (n == 20) begin
         bad_count++;
         tally_and_finish;
      end
      rd = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'h0;
      @(posedge clock);
   endtask
   task st(input logic [31:0] e);
      wb(0, 4'h4, 32'h0);
      `CHK(rd, e)
   endtask
   task tick;
      device_clock <= 0;
      @(posedge clock);
      device_clock <= 1;
      repeat (2) @(posedge clock);
   endtask
   initial begin
      repeat (12) @(posedge clock);
      rst_n <= 1;
      @(posedge clock);
      st(32'h100);
      {shift_not_load, serial_in, parallel_in} <= 10'h1A4;
      tick;
      st(32'h1A4);
      `CHK(last_stage_out, 1'h1)
      shift_not_load <= 1;
      tick;
      st(32'h049);
      `CHK(stream_room, 1'h0)
      clock_inhibit <= 1;
      tick;
      st(32'h049);
      {device_clock, serial_in} <= 2'h0;
      @(posedge clock);
      clock_inhibit <= 0;
      @(posedge clock);
      device_clock <= 1;
      repeat (2) @(posedge clock);
      st(32'h092);
      wb(1, 4'h0, 32'h2);
      tick;
      st(32'h292);
      wb(1, 4'h0, 32'h0);
      stall <= 0;
      repeat (4) @(posedge clock);
      `CHK(got[1:0], 2'h2)
      `CHK(stream_room, 1'h1)
      st(32'h192);
      overriding_reset_n <= 0;
      @(posedge clock);
      overriding_reset_n <= 1;
      st(32'h100);
      `CHK(last_stage_out, 1'h0)
      wb(0, 4'h8, 32'h0);
      `CHK(rd, 32'h0)
      tally_and_finish;
   end
endmodule
